// file: bench/sbp_bridge_model.sv
// Behavioural power bridge with current sense for the bridge PWM
`timescale 1ns/1ps
`default_nettype none
module sbp_bridge_model
#(
   parameter int unsigned TRIP_CYC = 2
)
(
   input  wire logic sys_clk,
   input  wire logic gate_hs_a,
   input  wire logic gate_ls_a,
   input  wire logic gate_hs_b,
   input  wire logic gate_ls_b,
   output var  logic cur_trip_pin,
   output var  logic shoot_seen
);
   int unsigned on_cnt;
   initial
   begin
      on_cnt = 0;
      cur_trip_pin = 1'b0;
      shoot_seen = 1'b0;
   end
   // Current builds only while the forward diagonal conducts
   always @(posedge sys_clk)
   begin
      if (gate_hs_a && gate_ls_b && !gate_hs_b && !gate_ls_a)
         on_cnt <= on_cnt + 1;
      else
         on_cnt <= 0;
      // Trips long before blanking ends, so only the filter can hold it off
      cur_trip_pin <= (on_cnt >= TRIP_CYC);
      // A leg with both switches on would short the supply
      if ((gate_hs_a && gate_ls_a) || (gate_hs_b && gate_ls_b))
         shoot_seen <= 1'b1;
   end
endmodule // sbp_bridge_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the stepper bridge PWM
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sbp_pkg::*;
   localparam logic [15:0] A_MASK = 16'h0804;
   localparam logic [15:0] A_FREQ = 16'h0808;
   localparam logic [15:0] A_CTL  = 16'h080C;
   localparam logic [15:0] A_STAT = 16'h0810;
   localparam logic [15:0] A_NONE = 16'h0900;
   logic        sys_clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [15:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp;
   logic        cur_trip_pin, zero_cross_pin, phase_pos_pin, factory_en_pin, shoot_seen;
   logic        gate_hs_a, gate_ls_a, gate_hs_b, gate_ls_b;
   wire  logic [3:0] g;
   int          fails, samples_checked, cyc;
   assign g = {gate_hs_a, gate_ls_a, gate_hs_b, gate_ls_b};
   sbp_bridge_pwm dut (.sys_clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .cur_trip_pin, .zero_cross_pin, .phase_pos_pin, .factory_en_pin,
      .gate_hs_a, .gate_ls_a, .gate_hs_b, .gate_ls_b);
   sbp_bridge_model #(.TRIP_CYC(2)) bridge (.sys_clk, .gate_hs_a, .gate_ls_a, .gate_hs_b, .gate_ls_b,
      .cur_trip_pin, .shoot_seen);
   always #5 sys_clk = ~sys_clk;
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Longest run is the frequency ramp, about 52k cycles
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         fails++;
         end_sim;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      // No local limit: only the bench timeout ends a stuck wait
      do
      begin
         @(posedge sys_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end
      while (s_bvalid !== 1'b1);
      r = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_arready) s_arvalid <= 1'b0;
      end
      while (s_rvalid !== 1'b1);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask
   task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d, exp);
      chk(32'(r), 32'(RESP_OKAY));
   endtask
   task automatic wait_pat(input logic [3:0] p);
      int n;
      n = 0;
      while (g !== p && n < 8000)
      begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   task automatic run_len(input logic [3:0] p, output int n);
      n = 0;
      while (g === p && n < 8000)
      begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rchk(A_MASK, 32'hCC);
      rchk(A_FREQ, 32'hAA);
      rchk(A_CTL, 32'h23);
      axr(A_NONE, d, r);
      chk(32'(r), 32'(RESP_DECERR));
      axw(A_NONE, 32'hFF, r);
      chk(32'(r), 32'(RESP_DECERR));
      $display("test reset done");
   endtask
   task automatic t_regs;
      wr(A_CTL, 32'h00);
      rchk(A_CTL, 32'h01);
      wr(A_CTL, 32'hFF);
      rchk(A_CTL, 32'hBF);
      wr(A_MASK, 32'h5A);
      rchk(A_MASK, 32'h5A);
      wr(A_FREQ, 32'h3C);
      rchk(A_FREQ, 32'h3C);
      $display("test registers done");
   endtask
   // Reverse 900 ns, forward 600 ns, turn-on delay 3 counts
   task automatic t_chop(input logic rh);
      int n;
      logic [3:0] rp;
      rp = rh ? 4'b1010 : 4'b0101;
      wr(A_MASK, 32'h30);
      wr(A_CTL, {24'h0, 2'b00, 1'b1, rh, 3'h3, 1'b0});
      wait_pat(rp);
      phase_pos_pin <= 1'b1;
      zero_cross_pin <= 1'b1;
      wait_pat(4'h0);
      run_len(4'h0, n);
      chk(32'(n), 32'd15);
      run_len(4'b1001, n);
      chk(32'(n), TIME_NS[0] / 10);
      run_len(4'b0110, n);
      chk(32'(n), TIME_NS[3] / 10);
      chk(32'(g), 32'(rp));
      zero_cross_pin <= 1'b0;
      $display("test chopping done");
   endtask
   task automatic t_quiet;
      int n;
      wr(A_CTL, 32'hA2);
      phase_pos_pin <= 1'b0;
      wait_pat(4'b1001);
      run_len(4'b1001, n);
      chk(32'(g), 32'h5);
      zero_cross_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk(32'(g), 32'h0);
      zero_cross_pin <= 1'b0;
      $display("test quiet done");
   endtask
   // Initial 25 kHz ramps to a 40 kHz ceiling, one step per period
   task automatic t_freq;
      logic [31:0] d;
      logic [1:0]  r;
      wr(A_CTL, 32'h22);
      wr(A_FREQ, 32'hF0);
      phase_pos_pin <= 1'b1;
      zero_cross_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      zero_cross_pin <= 1'b0;
      axr(A_STAT, d, r);
      chk(32'(d[6:0]), 32'd25);
      repeat (52000) @(posedge sys_clk);
      axr(A_STAT, d, r);
      chk(32'(d[6:0]), 32'd40);
      $display("test frequency done");
   endtask
   // Second reset in mid-run with the strap low: enable stays clear, bridge dark
   task automatic t_strap;
      factory_en_pin <= 1'b0;
      rstn <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rchk(A_CTL, 32'h22);
      rchk(A_MASK, 32'hCC);
      chk(32'(g), 32'h0);
      $display("test strap done");
   endtask
   initial
   begin
      {sys_clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata, zero_cross_pin, phase_pos_pin} = '0;
      s_wstrb = 4'hF;
      factory_en_pin = 1'b1;
      fails = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (10) @(posedge sys_clk);
      t_reset;
      t_regs;
      t_chop(1'b1);
      t_chop(1'b0);
      t_quiet;
      t_freq;
      t_strap;
      chk(32'(shoot_seen), 32'h0);
      end_sim;
   end
endmodule // tb
`default_nettype wire

// file: hdl/sbp_axil_slave.sv
// AXI4-Lite slave front end for the stepper bridge PWM registers
`timescale 1ns/1ps
`default_nettype none
module sbp_axil_slave
   import sbp_pkg::*;
#(
   parameter int unsigned AW = sbp_pkg::ADDR_W
)
(
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] s_awaddr,
   input  wire logic          s_awvalid,
   output var  logic          s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output var  logic          s_wready,
   output var  logic [1:0]    s_bresp,
   output var  logic          s_bvalid,
   input  wire logic          s_bready,
   input  wire logic          s_arvalid,
   output var  logic          s_arready,
   output var  logic [31:0]   s_rdata,
   output var  logic [1:0]    s_rresp,
   output var  logic          s_rvalid,
   input  wire logic          s_rready,
   output logic               wr_stb,
   output logic [AW-1:0]      wr_addr,
   output logic [31:0]        wr_data,
   output logic [3:0]         wr_be,
   input  wire logic          wr_ok,
   input  wire logic [31:0]   rd_data,
   input  wire logic          rd_ok
);
   logic aw_held_reg;
   logic w_held_reg;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic aw_held_next;
   logic w_held_next;
   logic bvalid_next;
   logic rvalid_next;

   // Writes wait while a response is pending, so one write is under way at most
   assign aw_take      = s_awvalid & s_awready;
   assign w_take       = s_wvalid & s_wready;
   assign ar_take      = s_arvalid & s_arready;
   assign wr_stb       = aw_held_reg & w_held_reg & ~s_bvalid;
   assign aw_held_next = aw_take | (aw_held_reg & ~wr_stb);
   assign w_held_next  = w_take | (w_held_reg & ~wr_stb);
   assign bvalid_next  = wr_stb | (s_bvalid & ~s_bready);
   assign rvalid_next  = ar_take | (s_rvalid & ~s_rready);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         s_awready   <= 1'b1;
         s_wready    <= 1'b1;
         s_bvalid    <= 1'b0;
         s_bresp     <= RESP_OKAY;
         s_arready   <= 1'b1;
         s_rvalid    <= 1'b0;
         s_rresp     <= RESP_OKAY;
         s_rdata     <= 32'h0;
         wr_addr     <= '0;
         wr_data     <= 32'h0;
         wr_be       <= 4'h0;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         s_awready   <= ~aw_held_next;
         s_wready    <= ~w_held_next;
         s_bvalid    <= bvalid_next;
         s_arready   <= ~rvalid_next;
         s_rvalid    <= rvalid_next;
         if (aw_take)
            wr_addr <= s_awaddr;
         if (w_take)
         begin
            wr_data <= s_wdata;
            wr_be   <= s_wstrb;
         end
         if (wr_stb)
            s_bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
         if (ar_take)
         begin
            s_rdata <= rd_data;
            s_rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
         end
      end
   end
endmodule // sbp_axil_slave
`default_nettype wire

// file: hdl/sbp_bridge_pwm.sv
// Current-chopping bridge PWM with its register file
`timescale 1ns/1ps
`default_nettype none
module sbp_bridge_pwm
   import sbp_pkg::*;
#(
   parameter int unsigned AW = sbp_pkg::ADDR_W
)
(
   input  wire logic          sys_clk,
   input  wire logic          rstn,
   input  wire logic [AW-1:0] s_awaddr,
   input  wire logic          s_awvalid,
   output var  logic          s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output var  logic          s_wready,
   output var  logic [1:0]    s_bresp,
   output var  logic          s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [AW-1:0] s_araddr,
   input  wire logic          s_arvalid,
   output var  logic          s_arready,
   output var  logic [31:0]   s_rdata,
   output var  logic [1:0]    s_rresp,
   output var  logic          s_rvalid,
   input  wire logic          s_rready,
   input  wire logic          cur_trip_pin,
   input  wire logic          zero_cross_pin,
   input  wire logic          phase_pos_pin,
   input  wire logic          factory_en_pin,
   output var  logic          gate_hs_a,
   output var  logic          gate_ls_a,
   output var  logic          gate_hs_b,
   output var  logic          gate_ls_b
);
   import sbp_pkg::*;

   if (AW < IDX_W + 2)
   begin : g_bad_aw
      $error("Address width too small for register map");
   end

   logic [1:0]       rst_sync_reg;
   logic             rst_n;
   logic [3:0]       pin_meta_reg;
   logic [3:0]       pin_sync_reg;
   logic [3:0]       pin_raw;
   logic             trip;
   logic             zc;
   logic             phase_pos;
   logic             zc_prev_reg;
   logic [7:0]       mask_reg;
   logic [7:0]       freq_reg;
   logic [7:0]       ctl_reg;
   logic [7:0]       ctl_next;
   logic [1:0]       cap_cnt_reg;
   logic             cap_now;
   logic             wr_stb;
   logic [AW-1:0]    wr_addr;
   logic [31:0]      wr_data;
   logic [3:0]       wr_be;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;
   logic             wr_ok;
   logic             rd_ok;
   logic [31:0]      rd_data;
   logic             wr_mask;
   logic             wr_freq;
   logic             wr_ctl;
   logic [8:0]       time_cyc [16];
   logic [8:0]       rev_cyc;
   logic [8:0]       fwd_cyc;
   logic [5:0]       dead_cyc;
   logic [6:0]       init_khz;
   logic [6:0]       max_khz;
   logic [6:0]       cur_khz_reg;
   logic [6:0]       cur_khz_next;
   logic [16:0]      acc_reg;
   logic [16:0]      acc_sum;
   logic [16:0]      acc_next;
   logic             period_end;
   logic             quiet;
   logic             bridge_off;
   logic             sync_event;
   sbp_state_e       state_reg;
   sbp_state_e       state_next;
   sbp_state_e       start_st;
   logic [8:0]       cnt_reg;
   logic [8:0]       cnt_inc;
   logic             dead_done;
   logic             fwd_blank_over;
   logic             rev_done;
   logic             recir_hi;
   logic             hs_a_next;
   logic             ls_a_next;
   logic             hs_b_next;
   logic             ls_b_next;

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // Pins are asynchronous to sys_clk; two flops each
   assign pin_raw = {factory_en_pin, phase_pos_pin, zero_cross_pin, cur_trip_pin};
   for (genvar gi = 0; gi < 4; gi++)
   begin : g_pin_sync
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            pin_meta_reg[gi] <= 1'b0;
            pin_sync_reg[gi] <= 1'b0;
         end
         else
         begin
            pin_meta_reg[gi] <= pin_raw[gi];
            pin_sync_reg[gi] <= pin_meta_reg[gi];
         end
      end
   end
   assign trip      = pin_sync_reg[0];
   assign zc        = pin_sync_reg[1];
   assign phase_pos = pin_sync_reg[2];

   sbp_axil_slave #(.AW(AW)) u_axil
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_stb    (wr_stb),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_be     (wr_be),
      .wr_ok     (wr_ok),
      .rd_data   (rd_data),
      .rd_ok     (rd_ok)
   );

   // Register decode; index is byte address over four
   assign wr_idx  = wr_addr[IDX_W+1:2];
   assign rd_idx  = s_araddr[IDX_W+1:2];
   assign wr_ok   = (wr_idx == IDX_MASK) | (wr_idx == IDX_FREQ) | (wr_idx == IDX_CTL) | (wr_idx == IDX_STAT);
   assign rd_ok   = (rd_idx == IDX_MASK) | (rd_idx == IDX_FREQ) | (rd_idx == IDX_CTL) | (rd_idx == IDX_STAT);
   assign wr_mask = wr_stb & wr_be[0] & (wr_idx == IDX_MASK);
   assign wr_freq = wr_stb & wr_be[0] & (wr_idx == IDX_FREQ);
   assign wr_ctl  = wr_stb & wr_be[0] & (wr_idx == IDX_CTL);
   assign rd_data = (rd_idx == IDX_MASK) ? {24'h0, mask_reg} :
                    (rd_idx == IDX_FREQ) ? {24'h0, freq_reg} :
                    (rd_idx == IDX_CTL)  ? {24'h0, ctl_reg} :
                    (rd_idx == IDX_STAT) ? {19'h0, state_reg, 1'b0, cur_khz_reg} : 32'h0;

   // Bit 6 reads zero; bit 0 keeps its factory value against writes
   assign ctl_next = {wr_data[CTL_QUIET], 1'b0, wr_data[CTL_SYNC:CTL_DLY_LSB], ctl_reg[CTL_ENABLE]};
   assign cap_now  = (cap_cnt_reg == 2'(STRAP_WAIT));

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mask_reg    <= MASK_RST;
         freq_reg    <= FREQ_RST;
         ctl_reg     <= CTL_RST;
         cap_cnt_reg <= 2'h0;
      end
      else
      begin
         if (wr_mask)
            mask_reg <= wr_data[7:0];
         if (wr_freq)
            freq_reg <= wr_data[7:0];
         if (wr_ctl)
            ctl_reg[7:1] <= ctl_next[7:1];
         // Strap sampled once after the synchroniser has filled
         if (cap_now)
            ctl_reg[CTL_ENABLE] <= pin_sync_reg[3];
         if (cap_cnt_reg != 2'h3)
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
      end
   end

   // Time code lookup, folded to constants per entry
   for (genvar gt = 0; gt < 16; gt++)
   begin : g_time
      assign time_cyc[gt] = 9'(ns_to_cyc(TIME_NS[gt]));
   end
   assign rev_cyc  = time_cyc[mask_reg[MASK_REV_LSB+:4]];
   assign fwd_cyc  = time_cyc[mask_reg[MASK_FWD_LSB+:4]];
   assign dead_cyc = 6'(ctl_reg[CTL_DLY_MSB:CTL_DLY_LSB] * DLY_STEP_CYC);
   assign init_khz = INIT_BASE_KHZ + 7'(freq_reg[FREQ_INIT_LSB+:4] * INIT_STEP_KHZ);
   assign max_khz  = MAX_BASE_KHZ + 7'(freq_reg[FREQ_MAX_LSB+:4] * MAX_STEP_KHZ);

   // Phase accumulator avoids a divider: one period per CLK_KHZ of sum
   assign quiet      = ctl_reg[CTL_QUIET];
   assign bridge_off = ~ctl_reg[CTL_ENABLE] | (quiet & zc);
   assign sync_event = ctl_reg[CTL_SYNC] & zc & ~zc_prev_reg & phase_pos;
   assign acc_sum    = acc_reg + 17'(cur_khz_reg);
   assign period_end = (state_reg != ST_OFF) & (acc_sum >= 17'(CLK_KHZ));
   assign acc_next   = (bridge_off | sync_event) ? 17'h0 :
                       period_end ? acc_sum - 17'(CLK_KHZ) : acc_sum;
   // Ramp one kHz per period; clamped so a lowered maximum also takes hold
   assign cur_khz_next = (state_reg == ST_OFF) | sync_event ? init_khz :
                         ~period_end ? cur_khz_reg :
                         (cur_khz_reg >= max_khz) ? max_khz : cur_khz_reg + 7'h1;

   assign start_st       = (dead_cyc == 6'h0) ? ST_FWD : ST_DEAD;
   assign cnt_inc        = (cnt_reg == 9'h1FF) ? cnt_reg : cnt_reg + 9'h1;
   assign dead_done      = (cnt_inc >= 9'(dead_cyc));
   // Trip only counts once the blanking time has passed
   assign fwd_blank_over = (cnt_inc >= fwd_cyc);
   assign rev_done       = (cnt_inc >= rev_cyc);

   always_comb
   begin
      state_next = state_reg;
      if (bridge_off)
         state_next = ST_OFF;
      else if (sync_event | period_end)
         state_next = start_st;
      else
      begin
         case (state_reg)
            ST_OFF:
               state_next = start_st;
            ST_DEAD:
               if (dead_done)
                  state_next = ST_FWD;
            ST_FWD:
               if (fwd_blank_over & trip)
                  state_next = quiet ? ST_RECIR : ST_REV;
            ST_REV:
               if (rev_done)
                  state_next = ST_RECIR;
            ST_RECIR:
               state_next = ST_RECIR;
            default:
               state_next = ST_OFF;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg   <= ST_OFF;
         cnt_reg     <= 9'h0;
         acc_reg     <= 17'h0;
         cur_khz_reg <= INIT_BASE_KHZ;
         zc_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         cnt_reg     <= (state_next != state_reg) | period_end | sync_event ? 9'h0 : cnt_inc;
         acc_reg     <= acc_next;
         cur_khz_reg <= cur_khz_next;
         zc_prev_reg <= zc;
      end
   end

   // Gate drive: forward A-high/B-low, reverse measure B-high/A-low
   assign recir_hi  = ctl_reg[CTL_RECIR];
   assign hs_a_next = (state_reg == ST_FWD) | ((state_reg == ST_RECIR) & recir_hi);
   assign ls_b_next = (state_reg == ST_FWD) | ((state_reg == ST_RECIR) & ~recir_hi);
   assign hs_b_next = (state_reg == ST_REV) | ((state_reg == ST_RECIR) & recir_hi);
   assign ls_a_next = (state_reg == ST_REV) | ((state_reg == ST_RECIR) & ~recir_hi);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gate_hs_a <= 1'b0;
         gate_ls_a <= 1'b0;
         gate_hs_b <= 1'b0;
         gate_ls_b <= 1'b0;
      end
      else
      begin
         gate_hs_a <= hs_a_next;
         gate_ls_a <= ls_a_next;
         gate_hs_b <= hs_b_next;
         gate_ls_b <= ls_b_next;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_fwd_trip;
      (state_reg == ST_FWD) && (state_next == ST_REV);
   endsequence

   sequence s_dead_last;
      (state_reg == ST_DEAD) && dead_done && !bridge_off && !sync_event && !period_end;
   endsequence

   chk_reset_values: assert property ($rose(rst_n) |-> mask_reg == 8'hCC && freq_reg == 8'hAA)
      else $error("reset values of blanking or frequency wrong");

   chk_ctl_bit6: assert property (ctl_reg[6] == 1'b0)
      else $error("unused control bit set");

   chk_enable_locked: assert property (wr_ctl && !cap_now |=> ctl_reg[0] == $past(ctl_reg[0]))
      else $error("bridge enable changed by write");

   chk_blank_fwd: assert property (s_fwd_trip |-> cnt_reg + 9'h1 >= fwd_cyc && trip)
      else $error("forward period ended inside blanking");

   chk_quiet_norev: assert property (quiet && state_reg == ST_FWD |=> state_reg != ST_REV)
      else $error("reverse measure entered in quiet mode");

   chk_quiet_zc: assert property (quiet && zc |=> state_reg == ST_OFF ##1 !gate_hs_a && !gate_ls_b)
      else $error("bridge not off at zero cross in quiet mode");

   chk_recir_side: assert property (state_reg == ST_RECIR |=>
                                    gate_hs_a == $past(recir_hi) && gate_ls_a == !$past(recir_hi))
      else $error("recirculation on wrong side");

   chk_dead_time: assert property (s_dead_last |=> state_reg == ST_FWD && $past(cnt_reg) + 9'h1 >= 9'(dead_cyc))
      else $error("turn-on delay wrong");

   chk_rev_time: assert property (state_reg == ST_REV && state_next == ST_RECIR && !period_end
                                  |-> cnt_reg + 9'h1 == rev_cyc || $changed(rev_cyc))
      else $error("reverse measure time wrong");

   chk_freq_clamp: assert property (period_end |=> cur_khz_reg <= max_khz || $changed(freq_reg))
      else $error("frequency above maximum");

   chk_freq_start: assert property (state_reg == ST_OFF |=> cur_khz_reg == $past(init_khz))
      else $error("frequency not at initial value");

   chk_sync_restart: assert property (sync_event && !bridge_off |=> acc_reg == 17'h0 && cnt_reg == 9'h0)
      else $error("zero-cross sync did not restart period");
endmodule // sbp_bridge_pwm
`default_nettype wire

// file: hdl/sbp_pkg.sv
// Package of constants, register map and state codes for the stepper bridge PWM
package sbp_pkg;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned CLK_KHZ       = 100000;
   localparam int unsigned ADDR_W        = 16;
   localparam int unsigned IDX_W         = 14;
   localparam logic [13:0] IDX_MASK      = 14'h0201;
   localparam logic [13:0] IDX_FREQ      = 14'h0202;
   localparam logic [13:0] IDX_CTL       = 14'h0203;
   localparam logic [13:0] IDX_STAT      = 14'h0204;
   localparam logic [7:0]  MASK_RST      = 8'hCC;
   localparam logic [7:0]  FREQ_RST      = 8'hAA;
   localparam logic [7:0]  CTL_RST       = 8'h22;
   localparam int unsigned CTL_QUIET     = 7;
   localparam int unsigned CTL_UNUSED    = 6;
   localparam int unsigned CTL_SYNC      = 5;
   localparam int unsigned CTL_RECIR     = 4;
   localparam int unsigned CTL_DLY_MSB   = 3;
   localparam int unsigned CTL_DLY_LSB   = 1;
   localparam int unsigned CTL_ENABLE    = 0;
   localparam int unsigned MASK_REV_LSB  = 4;
   localparam int unsigned MASK_FWD_LSB  = 0;
   localparam int unsigned FREQ_INIT_LSB = 4;
   localparam int unsigned FREQ_MAX_LSB  = 0;
   localparam int unsigned STAT_STATE_LSB = 8;
   localparam logic [6:0]  INIT_BASE_KHZ = 7'h0A;
   localparam logic [6:0]  INIT_STEP_KHZ = 7'h01;
   localparam logic [6:0]  MAX_BASE_KHZ  = 7'h28;
   localparam logic [6:0]  MAX_STEP_KHZ  = 7'h02;
   localparam int unsigned DLY_STEP_NS   = 50;
   localparam int unsigned DLY_STEP_CYC  = (DLY_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STRAP_WAIT    = 2;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_DECERR   = 2'h3;
   localparam int unsigned TIME_NS [16] = '{600, 700, 800, 900, 1000, 1100, 1200, 1400,
                                            1600, 1800, 2000, 2200, 2500, 2800, 3100, 3400};

   typedef enum logic [4:0]
   {
      ST_OFF   = 5'h01,
      ST_DEAD  = 5'h02,
      ST_FWD   = 5'h04,
      ST_REV   = 5'h08,
      ST_RECIR = 5'h10
   } sbp_state_e;

   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      return (ns * CLK_MHZ + 999) / 1000;
   endfunction
endpackage
